/* File: pcg_regs.vh */
// Register map, field positions, reset values and fixed rates of the PCM
// clock and frame-sync generator. Definitions only; included by pcg_core.v.
`ifndef PCG_REGS_VH
`define PCG_REGS_VH
// Byte addresses of the word registers.
`define PCG_ADDR_CFG      8'h00
`define PCG_ADDR_JIT      8'h04
`define PCG_ADDR_SCALE    8'h08
`define PCG_ADDR_GAIN     8'h0C
`define PCG_ADDR_STATUS   8'h10
// Reset values.
`define PCG_CFG_RST       32'h0080_0000
`define PCG_JIT_RST       32'h0808_0177
`define PCG_SCALE_RST     16'h0000
`define PCG_GAIN_RST      3'h0
// Main configuration word fields.
`define PCG_SLAVE         1
`define PCG_SHORT         2
`define PCG_SIGNX         4
`define PCG_LSBF          5
`define PCG_REL_EN        6
`define PCG_REL_RISE      7
`define PCG_SUPP          8
`define PCG_MUTE          10
`define PCG_FAST          11
`define PCG_LONG16        12
`define PCG_RATE_HI       22
`define PCG_RATE_LO       21
`define PCG_FMT_HI        28
`define PCG_FMT_LO        27
// Rate and format encodings.
`define PCG_RATE_128      2'h1
`define PCG_RATE_512      2'h2
`define PCG_FMT_13        2'h0
`define PCG_FMT_16        2'h1
`define PCG_FMT_8W        2'h2
`define PCG_FMT_8N        2'h3
// Low-jitter word fields and scale-select bit.
`define PCG_LIM_HI        12
`define PCG_RTE_HI        23
`define PCG_RTE_LO        16
`define PCG_DIV_HI        31
`define PCG_DIV_LO        24
`define PCG_SCALE_BIT     12
// Synthesis: 200 MHz system clock, 24 MHz unit; step 3/25 per cycle.
`define PCG_SYS_MUL       18'h00019
`define PCG_UNIT_MUL      18'h00003
// Fixed slow-source settings: limit and rates.
`define PCG_SLOW_LIM      13'h0177
`define PCG_SLOW_R128     8'h02
`define PCG_SLOW_R256     8'h04
`define PCG_SLOW_R512     8'h08
// Bits per 8 kHz frame at each slow rate.
`define PCG_FLEN_128      11'h010
`define PCG_FLEN_256      11'h020
`define PCG_FLEN_512      11'h040
// Sync pulse lengths, slot lengths, multiplier.
`define PCG_SYNC8         11'h008
`define PCG_SYNC16        11'h010
`define PCG_MULT8         3'h3
`define PCG_SLOT16        5'h10
`define PCG_SLOT8         5'h08
`endif

/* File: pcg_core.v */
// PCM port configuration registers, bit clock / frame sync synthesis and
// the slot-zero serial shifter. Assumes an AHB-Lite master on clk_sys and
// an external codec whose pins are resolved by the surrounding pad logic.
//
// Summary of operation
// - Slow source offers 128/256/512 kHz, 8 kHz sync.
// - Bit 11 picks fast or slow synthesis source.
// - Fast bit clock is rate/limit times 24 MHz.
// - Frame is divider or eight times divider bits.
// - Jitter word: limit, rate, frame divider fields.
// - Fast long sync lasts 8 or 16 bits.
// - Bit 1 selects master generation or slave following.
// - Bit 2 selects rising or falling frame edge.
// - Bit 4 selects padding or sign extension.
// - Bit 5 selects MSB-first or LSB-first order.
// - Bit 6 releases output after last slot bit.
// - Bit 7 moves release to rising edge.
// - Bit 8 holds master sync low, clock runs.
// - Bit 10 forces every output data bit zero.
// - Rate field picks slow bit clock frequency.
// - Format field picks sample width and slot.
// - Main word resets to 0x00800000.
// - Active-slot field resets one, selects nothing.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`include "pcg_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module pcg_core
(
  input  wire        clk_sys,     // System clock, 200 MHz.
  input  wire        rst,         // Asynchronous reset, active high.
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        pcm_clk_i,   // Bit clock pin, input side.
  output reg         pcm_clk_o,
  output wire        pcm_clk_oe,
  input  wire        pcm_sync_i,  // Frame sync pin, input side.
  output reg         pcm_sync_o,
  output wire        pcm_sync_oe,
  input  wire        pcm_din,     // Serial receive data pin.
  output reg         pcm_dout,
  output reg         pcm_dout_oe,
  input  wire [15:0] tx_sample,   // Sample sent in the next slot.
  output reg         tx_take,     // Pulse: tx_sample was captured.
  output reg  [15:0] rx_sample,   // Last received sample.
  output reg         rx_valid     // Pulse: rx_sample updated.
);

  // =====================================================================
  // Slot state machine encodings
  // =====================================================================
  localparam [2:0] ST_IDLE  = 3'b001;  // Waiting for a frame.
  localparam [2:0] ST_ARMED = 3'b010;  // Slave saw sync, next rise starts.
  localparam [2:0] ST_SLOT  = 3'b100;  // Shifting slot zero.

  // Bit position inside the slot word for serial index k.
  function [3:0] bitpos;
    input [4:0] k;
    input       narrow;
    input       lsbf;
    begin
      if (lsbf)
        bitpos = k[3:0];
      else if (narrow)
        bitpos = 4'h7 - k[3:0];
      else
        bitpos = 4'hF - k[3:0];
    end
  endfunction

  // =====================================================================
  // Register file
  // =====================================================================
  reg  [31:0] cfg_r;     // Main configuration word.
  reg  [31:0] jit_r;     // Low-jitter divider word.
  reg  [15:0] scale_r;   // Frame divider scale word.
  reg  [2:0]  gain_r;    // Padding gain for 13-bit samples.
  reg         wr_pend_r; // Write data phase pending.
  reg  [7:0]  wr_addr_r; // Address captured in the address phase.
  reg  [7:0]  rd_addr;   // Address used for the read mux.
  reg  [2:0]  st_r;
  reg  [4:0]  k_r;
  reg  [10:0] fcnt_r;
  reg         sync_lvl_r;

  wire        addr_ok = hsel & hready & htrans[1];

  assign hreadyout = 1'b1;  // Zero wait states.
  assign hresp     = 1'b0;  // Always OKAY.

  // Capture write address phases; reads are answered in the data phase.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok & hwrite;
      wr_addr_r <= haddr;
    end
  end

  // Store data phase writes; unmapped addresses are ignored.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_r   <= `PCG_CFG_RST;
      jit_r   <= `PCG_JIT_RST;
      scale_r <= `PCG_SCALE_RST;
      gain_r  <= `PCG_GAIN_RST;
    end
    else if (wr_pend_r)
    begin
      case (wr_addr_r)
        `PCG_ADDR_CFG:   cfg_r   <= hwdata;
        `PCG_ADDR_JIT:   jit_r   <= hwdata;
        `PCG_ADDR_SCALE: scale_r <= hwdata[15:0];
        `PCG_ADDR_GAIN:  gain_r  <= hwdata[2:0];
        default:         gain_r  <= gain_r;
      endcase
    end
  end

  // Read data registered at the address phase; unmapped reads zero.
  always @*
  begin
    rd_addr = haddr;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (addr_ok & ~hwrite)
    begin
      case (rd_addr)
        `PCG_ADDR_CFG:    hrdata <= cfg_r;
        `PCG_ADDR_JIT:    hrdata <= jit_r;
        `PCG_ADDR_SCALE:  hrdata <= {16'h0000, scale_r};
        `PCG_ADDR_GAIN:   hrdata <= {29'h0, gain_r};
        `PCG_ADDR_STATUS: hrdata <= {8'h00, sync_lvl_r, fcnt_r, k_r, 4'h0, st_r};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Decoded configuration fields.
  wire        slave  = cfg_r[`PCG_SLAVE];
  wire        short  = cfg_r[`PCG_SHORT];
  wire        fast   = cfg_r[`PCG_FAST];
  wire [1:0]  rsel   = cfg_r[`PCG_RATE_HI:`PCG_RATE_LO];
  wire [1:0]  fmt    = cfg_r[`PCG_FMT_HI:`PCG_FMT_LO];
  wire        narrow = (fmt == `PCG_FMT_8N);
  wire [4:0]  slen   = narrow ? `PCG_SLOT8 : `PCG_SLOT16;
  wire        lsbf   = cfg_r[`PCG_LSBF];

  // =====================================================================
  // Bit clock synthesis
  // =====================================================================
  reg  [12:0] lim;
  reg  [7:0]  rte;
  reg  [10:0] flen;
  reg  [10:0] slen_sync;
  reg  [17:0] acc_r;
  reg  [17:0] acc_nxt;
  reg         clk_gen_r;

  // Pick counter limit, rate, frame and sync length per source.
  always @*
  begin
    if (fast)
    begin
      lim = jit_r[`PCG_LIM_HI:0];
      rte = jit_r[`PCG_RTE_HI:`PCG_RTE_LO];
      if (scale_r[`PCG_SCALE_BIT])
        flen = {3'h0, jit_r[`PCG_DIV_HI:`PCG_DIV_LO]};
      else
        flen = {3'h0, jit_r[`PCG_DIV_HI:`PCG_DIV_LO]} << `PCG_MULT8;
      slen_sync = cfg_r[`PCG_LONG16] ? `PCG_SYNC16 : `PCG_SYNC8;
    end
    else
    begin
      lim = `PCG_SLOW_LIM;
      slen_sync = `PCG_SYNC8;
      case (rsel)
        `PCG_RATE_128:
        begin
          rte  = `PCG_SLOW_R128;
          flen = `PCG_FLEN_128;
        end
        `PCG_RATE_512:
        begin
          rte  = `PCG_SLOW_R512;
          flen = `PCG_FLEN_512;
        end
        default:
        begin
          rte  = `PCG_SLOW_R256;
          flen = `PCG_FLEN_256;
        end
      endcase
    end
  end

  // Phase accumulator in units of 1/25 of a 24 MHz tick.
  wire [17:0] modu = {5'h00, lim} * `PCG_SYS_MUL;
  wire [17:0] step = {10'h000, rte} * `PCG_UNIT_MUL;
  wire        gen_hi = (acc_nxt < {1'b0, modu[17:1]});

  always @*
  begin
    acc_nxt = acc_r + step;
    if (modu == 18'h00000)
      acc_nxt = 18'h00000;
    else if (acc_nxt >= modu)
      acc_nxt = acc_nxt - modu;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      acc_r     <= 18'h00000;
      clk_gen_r <= 1'b0;
    end
    else
    begin
      acc_r     <= acc_nxt;
      clk_gen_r <= gen_hi;
    end
  end

  wire m_rise = gen_hi & ~clk_gen_r;

  // =====================================================================
  // Pin input synchronisers: three flops, change once stages 2 and 3 agree
  // =====================================================================
  reg  [2:0] sy_clk_r;
  reg  [2:0] sy_sync_r;
  reg  [2:0] sy_din_r;
  reg        clk_lvl_r;
  wire       clk_lvl_nxt = (sy_clk_r[1] == sy_clk_r[2]) ? sy_clk_r[2] : clk_lvl_r;
  wire       sync_nxt    = (sy_sync_r[1] == sy_sync_r[2]) ? sy_sync_r[2] : sync_lvl_r;
  reg        din_lvl_r;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sy_clk_r   <= 3'h0;
      sy_sync_r  <= 3'h0;
      sy_din_r   <= 3'h0;
      clk_lvl_r  <= 1'b0;
      sync_lvl_r <= 1'b0;
      din_lvl_r  <= 1'b0;
    end
    else
    begin
      sy_clk_r   <= {sy_clk_r[1:0], pcm_clk_i};
      sy_sync_r  <= {sy_sync_r[1:0], pcm_sync_i};
      sy_din_r   <= {sy_din_r[1:0], pcm_din};
      clk_lvl_r  <= clk_lvl_nxt;
      sync_lvl_r <= sync_nxt;
      if (sy_din_r[1] == sy_din_r[2])
        din_lvl_r <= sy_din_r[2];
    end
  end

  // Bit clock edges from the generator or the followed pin.
  wire s_rise = clk_lvl_nxt & ~clk_lvl_r;
  wire s_fall = ~clk_lvl_nxt & clk_lvl_r;
  wire m_fall = ~gen_hi & clk_gen_r;
  wire rise   = slave ? s_rise : m_rise;
  wire fall   = slave ? s_fall : m_fall;

  // Slave frame edge: rising for long sync, falling for short.
  wire s_edge = short ? (~sync_nxt & sync_lvl_r) : (sync_nxt & ~sync_lvl_r);

  // =====================================================================
  // Master frame counter and sync output
  // =====================================================================
  wire [10:0] fcnt_nxt = (fcnt_r >= flen - 11'h001) ? 11'h000 : fcnt_r + 11'h001;
  wire        m_start  = m_rise & (fcnt_nxt == 11'h000);

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fcnt_r     <= 11'h000;
      pcm_sync_o <= 1'b0;
      pcm_clk_o  <= 1'b0;
    end
    else
    begin
      pcm_clk_o <= gen_hi;
      if (m_rise)
      begin
        fcnt_r <= fcnt_nxt;
        if (cfg_r[`PCG_SUPP])
          pcm_sync_o <= 1'b0;
        else if (short)
          pcm_sync_o <= (fcnt_nxt == flen - 11'h001);
        else
          pcm_sync_o <= (fcnt_nxt < slen_sync);
      end
    end
  end

  assign pcm_clk_oe  = ~slave;
  assign pcm_sync_oe = ~slave;

  // =====================================================================
  // Slot-zero shifter
  // =====================================================================
  reg  [15:0] word;
  reg  [15:0] tx_word_r;
  reg  [15:0] rx_word_r;
  reg  [15:0] rx_full;
  reg  [15:0] word_rx;   // Received slot word as a sign-extended sample.
  wire        start  = slave ? (rise & st_r[2'd1]) : m_start;
  wire [4:0]  k_nxt  = k_r + 5'h01;
  wire        last   = (k_r == slen - 5'h01);
  wire        rel_en = cfg_r[`PCG_REL_EN];
  wire        mute   = cfg_r[`PCG_MUTE];

  // Format the outgoing sample into its slot word.
  always @*
  begin
    case (fmt)
      `PCG_FMT_13:
        if (cfg_r[`PCG_SIGNX])
          word = {{3{tx_sample[12]}}, tx_sample[12:0]};
        else
          word = {tx_sample[12:0], gain_r};
      `PCG_FMT_8W:
        if (cfg_r[`PCG_SIGNX])
          word = {{8{tx_sample[7]}}, tx_sample[7:0]};
        else
          word = {tx_sample[7:0], 8'h00};
      `PCG_FMT_8N:
        word = {8'h00, tx_sample[7:0]};
      default:
        word = tx_sample;
    endcase
  end

  // Unpack the received word into a sign-extended sample.
  always @*
  begin
    rx_full = rx_word_r;
    rx_full[bitpos(k_r, narrow, lsbf)] = din_lvl_r;
    if (fmt == `PCG_FMT_16)
      word_rx = rx_full;
    else if (fmt == `PCG_FMT_8N || (fmt == `PCG_FMT_8W && cfg_r[`PCG_SIGNX]))
      word_rx = {{8{rx_full[7]}}, rx_full[7:0]};
    else if (fmt == `PCG_FMT_8W)
      word_rx = {{8{rx_full[15]}}, rx_full[15:8]};
    else if (cfg_r[`PCG_SIGNX])
      word_rx = {{3{rx_full[12]}}, rx_full[12:0]};
    else
      word_rx = {{3{rx_full[15]}}, rx_full[15:3]};
  end

  // Slot sequencing: drive on rises, sample on falls.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r        <= ST_IDLE;
      k_r         <= 5'h00;
      tx_word_r   <= 16'h0000;
      rx_word_r   <= 16'h0000;
      rx_sample   <= 16'h0000;
      rx_valid    <= 1'b0;
      tx_take     <= 1'b0;
      pcm_dout    <= 1'b0;
      pcm_dout_oe <= 1'b1;
    end
    else
    begin
      tx_take  <= 1'b0;
      rx_valid <= 1'b0;
      if (!rel_en)
        pcm_dout_oe <= 1'b1;
      if (start)
      begin
        st_r        <= ST_SLOT;
        k_r         <= 5'h00;
        tx_word_r   <= word;
        tx_take     <= 1'b1;
        pcm_dout_oe <= 1'b1;
        pcm_dout    <= ~mute & word[bitpos(5'h00, narrow, lsbf)];
      end
      else
      begin
        case (st_r)
          ST_IDLE:
            // The codec moves sync on its clock rise, so arm on the edge itself.
            if (slave & s_edge)
              st_r <= ST_ARMED;
          ST_ARMED:
            if (~slave)
              st_r <= ST_IDLE;
          ST_SLOT:
          begin
            if (fall)
            begin
              rx_word_r <= rx_full;
              if (last)
              begin
                rx_sample <= word_rx;
                rx_valid  <= 1'b1;
                if (rel_en & ~cfg_r[`PCG_REL_RISE])
                  pcm_dout_oe <= 1'b0;
              end
            end
            if (rise)
            begin
              if (last)
              begin
                st_r     <= ST_IDLE;
                pcm_dout <= 1'b0;
                if (rel_en & cfg_r[`PCG_REL_RISE])
                  pcm_dout_oe <= 1'b0;
              end
              else
              begin
                k_r      <= k_nxt;
                pcm_dout <= ~mute & tx_word_r[bitpos(k_nxt, narrow, lsbf)];
              end
            end
          end
          default:
            st_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // pcg_core

`default_nettype wire

/* File: pcg_core_monitor.sv */
// Assertion checker for the PCM clock and frame-sync generator.
// Assumes the register map of pcg_regs.vh and a zero-wait bus slave.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_regs.vh"

module pcg_core_monitor
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        pcm_clk_o,
  input wire logic        pcm_clk_oe,
  input wire logic        pcm_sync_o,
  input wire logic        pcm_sync_oe,
  input wire logic        pcm_dout,
  input wire logic        pcm_dout_oe
);
  // ==========================================================
  // Shadow registers and edge counters.
  logic [31:0] cfg_r;  // Copy of the main configuration word.
  logic [31:0] jit_r;  // Copy of the divider word.
  logic [15:0] scl_r;  // Copy of the scale word.
  logic [7:0]  a_r;    // Address of the transfer in data phase.
  logic        w_r;    // A write is in its data phase.
  logic [15:0] qt_r;   // Cycles since the last register write.
  logic [15:0] cc_r;   // Cycles since the last bit clock rise.
  logic [7:0]  bc_r;   // Bit clock rises since the last sync rise.
  logic [7:0]  sw_r;   // Bit clock rises while sync is high.
  logic [1:0]  ns_r;   // Sync rises since the last write, saturating.
  logic        ck_q;   // Bit clock one cycle ago.
  logic        sy_q;   // Sync one cycle ago.
  wire rise = pcm_clk_o & !ck_q;
  wire syr = pcm_sync_o & !sy_q;
  wire syf = !pcm_sync_o & sy_q;
  wire mst = !cfg_r[1];
  wire fst = cfg_r[11];
  wire [1:0] rc = cfg_r[22:21];
  wire [7:0] rte = fst ? jit_r[23:16] : (rc == 2'h1 ? 8'h02 : rc == 2'h2 ? 8'h08 : 8'h04);
  wire [12:0] lim = fst ? jit_r[12:0] : 13'h0177;
  wire [31:0] per = ({19'h0, lim} * 32'h19) / ({24'h0, rte} * 32'h3);
  wire [10:0] flen = fst ? (scl_r[12] ? {3'h0, jit_r[31:24]} : {jit_r[31:24], 3'h0})
                         : (rc == 2'h1 ? 11'h010 : rc == 2'h2 ? 11'h040 : 11'h020);
  wire [7:0] swid = (fst && cfg_r[12]) ? 8'h10 : 8'h08;

  // Tracks bus writes and measures clock and sync timing.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_r <= `PCG_CFG_RST;
      jit_r <= `PCG_JIT_RST;
      scl_r <= `PCG_SCALE_RST;
      {w_r, a_r, qt_r, cc_r, bc_r, sw_r, ns_r, ck_q, sy_q} <= '0;
    end
    else
    begin
      w_r <= hsel & hready & htrans[1] & hwrite;
      if (hsel & hready & htrans[1])
        a_r <= haddr;
      if (w_r && a_r == `PCG_ADDR_CFG)
        cfg_r <= hwdata;
      if (w_r && a_r == `PCG_ADDR_JIT)
        jit_r <= hwdata;
      if (w_r && a_r == `PCG_ADDR_SCALE)
        scl_r <= hwdata[15:0];
      qt_r <= w_r ? 16'h0 : qt_r + {15'h0, qt_r != 16'hFFFF};
      ck_q <= pcm_clk_o;
      sy_q <= pcm_sync_o;
      cc_r <= rise ? 16'h1 : cc_r + 16'h1;
      bc_r <= syr ? 8'h0 : bc_r + {7'h0, rise};
      sw_r <= syr ? {7'h0, rise} : sw_r + {7'h0, rise & pcm_sync_o};
      ns_r <= w_r ? 2'h0 : ns_r + {1'b0, syr & (ns_r != 2'h3)};
    end
  end

  // ==========================================================
  // Properties.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Master mode, sync not suppressed, three sync rises since a write.
  sequence s_settled;
    mst && !cfg_r[8] && ns_r == 2'h3;
  endsequence
  // A read of the main word: address phase, then data phase.
  sequence s_cfg_read;
    hsel && hready && htrans[1] && !hwrite && haddr == `PCG_ADDR_CFG ##1 hready;
  endsequence
  property p_oe_mode;
    pcm_clk_oe == mst && pcm_sync_oe == mst;
  endproperty
  property p_sync_hold;
    mst && cfg_r[8] && qt_r > 16'h1 |-> !pcm_sync_o;
  endproperty
  property p_mute;
    cfg_r[10] && qt_r > 16'h1 |-> !pcm_dout;
  endproperty
  property p_drive;
    !cfg_r[6] && qt_r > 16'h1 |-> pcm_dout_oe;
  endproperty
  property p_clk_per;
    mst && rise && {16'h0, qt_r} > per * 4 |-> {16'h0, cc_r} >= per && {16'h0, cc_r} <= per + 1;
  endproperty
  property p_frame;
    s_settled ##0 syr |-> {3'h0, bc_r} + {10'h0, rise} == flen;
  endproperty
  property p_sync_w;
    s_settled ##0 (syf && !cfg_r[2]) |-> sw_r == swid || sw_r == swid - 8'h1;
  endproperty
  property p_cfg_read;
    s_cfg_read |-> hrdata == cfg_r;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin enables do not follow mode");
  a_sync_hold: assert property (p_sync_hold) else $error("sync high while held");
  a_mute: assert property (p_mute) else $error("data high while muted");
  a_drive: assert property (p_drive) else $error("output released");
  a_clk_per: assert property (p_clk_per) else $error("bit clock period");
  a_frame: assert property (p_frame) else $error("frame length in bits");
  a_sync_w: assert property (p_sync_w) else $error("long sync width");
  a_cfg_read: assert property (p_cfg_read) else $error("main word readback");
endmodule // pcg_core_monitor

bind pcg_core pcg_core_monitor u_mon (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .pcm_clk_o, .pcm_clk_oe, .pcm_sync_o, .pcm_sync_oe,
  .pcm_dout, .pcm_dout_oe);
`default_nettype wire

/* File: pcg_codec.sv */
// Behavioural model of the external voice codec on the PCM pins.
// Assumes the bench resolves clock and sync from the device's output enables.
`timescale 1ns/100ps
`default_nettype none

module pcg_codec
(
  input wire logic        gen,         // High: codec makes clock and sync.
  input wire logic        short_sync,  // High: short sync framing.
  input wire logic [15:0] word,        // Sample sent MSB first.
  input wire logic        bclk,        // Resolved bit clock.
  input wire logic        fsync,       // Resolved frame sync.
  input wire logic        dout,        // Device serial output.
  output logic            clk_p,
  output logic            sync_p,
  output logic            din,
  output logic [15:0]     cap          // Last 16 slot bits received.
);
  int   n;    // Bit count within the frame this codec makes.
  int   idx;  // Bit index within the slot, 99 when idle.
  logic sq;   // Sync level at the previous rise.
  initial
  begin
    {clk_p, sync_p, din, cap, sq} = '0;
    n = 0;
    idx = 99;
  end
  // Bit clock runs only while the codec is the clock source.
  always
  begin
    #50;
    if (gen)
      clk_p = ~clk_p;
  end
  // One-bit sync pulse at the head of each 32-bit frame.
  always @(posedge clk_p)
  begin
    n = (n == 31) ? 0 : n + 1;
    sync_p <= gen && n == 0;
  end
  // Slot start: rise after a rising or falling sync edge, or device sync.
  always @(posedge bclk)
  begin
    #1;
    if (gen ? n == (short_sync ? 2 : 1) : (fsync && !sq))
      idx = 0;
    else if (idx < 99)
      idx = idx + 1;
    sq = fsync;
    din = (idx < 16) ? word[15 - idx] : ~din;
  end
  // Receives the device's slot bits on the falling edge.
  always @(negedge bclk)
  begin
    if (idx < 16)
      cap = {cap[14:0], dout};
  end
endmodule // pcg_codec
`default_nettype wire

/* File: pcg_core_test.sv */
// Self-checking bench for the PCM clock and frame-sync generator.
// Assumes pcg_core, the codec model and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none

module pcg_core_test;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] tx_sample = 16'h0;
  logic        gen = 0;
  logic        shs = 0;
  logic [15:0] pw = 16'h0;
  logic [31:0] seed = 32'h183BA391;
  logic [31:0] rd;
  logic [31:0] cv;
  logic [15:0] s;
  int          n_fail = 0;
  int          n_compared = 0;
  int          wn;
  int          p;
  int          e;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        pcm_clk_o, pcm_clk_oe, pcm_sync_o, pcm_sync_oe, pcm_dout, pcm_dout_oe;
  wire        tx_take, rx_valid, clk_p, sync_p, din;
  wire [15:0] rx_sample, cap;
  wire bclk = pcm_clk_oe ? pcm_clk_o : clk_p;
  wire fsy = pcm_sync_oe ? pcm_sync_o : sync_p;

  always #2.5 clk_sys = ~clk_sys;

  pcg_core uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pcm_clk_i(bclk), .pcm_clk_o(pcm_clk_o),
    .pcm_clk_oe(pcm_clk_oe), .pcm_sync_i(fsy), .pcm_sync_o(pcm_sync_o),
    .pcm_sync_oe(pcm_sync_oe), .pcm_din(din), .pcm_dout(pcm_dout),
    .pcm_dout_oe(pcm_dout_oe), .tx_sample(tx_sample), .tx_take(tx_take),
    .rx_sample(rx_sample), .rx_valid(rx_valid));
  pcg_codec u_codec (.gen(gen), .short_sync(shs), .word(pw), .bclk(bclk), .fsync(fsy),
    .dout(pcm_dout), .clk_p(clk_p), .sync_p(sync_p), .din(din), .cap(cap));

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bit order reversal for LSB-first slots.
  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rev[i] = v[15 - i];
  endfunction
  function automatic logic hit(input int w);
    case (w)
      0: return tx_take === 1'b1;
      1: return rx_valid === 1'b1;
      2: return pcm_clk_o === 1'b0;
      default: return pcm_clk_o === 1'b1;
    endcase
  endfunction
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for an event; wn returns the cycles taken.
  task automatic wt(input int w, input int lim);
    wn = 0;
    do
    begin
      @(posedge clk_sys);
      wn++;
    end
    while (!hit(w) && wn < lim);
    if (wn >= lim)
    begin
      n_fail++;
      stop_test();
    end
  endtask
  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    for (int k = 0; k < 2; k++)
    begin
      wn = 0;
      do
      begin
        @(posedge clk_sys);
        wn++;
      end
      while (hreadyout !== 1'b1 && wn < 100);
      htrans <= 2'h0;
      hwdata <= d;
      if (wn >= 100)
      begin
        n_fail++;
        stop_test();
      end
    end
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 8'h00, 0);
    chk("cfg reset", rd, 32'h0080_0000);
    bus(0, 8'h04, 0);
    chk("jitter reset", rd, 32'h0808_0177);
    bus(1, 8'h14, rnd());
    bus(0, 8'h14, 0);
    chk("unmapped", rd, 32'h0);
    cv = rnd();
    bus(1, 8'h04, cv);
    bus(0, 8'h04, 0);
    chk("jitter rw", rd, cv);
    // Slow source: rate codes 1, 0 and 2, then one bit clock period.
    for (int r = 0; r < 3; r++)
    begin
      bus(1, 8'h00, 32'h0080_0000 | ({30'h0, r == 0 ? 2'h1 : r == 1 ? 2'h0 : 2'h2} << 21));
      repeat (4)
      begin
        wt(2, 4000);
        wt(3, 4000);
      end
      wt(2, 4000);
      p = wn;
      wt(3, 4000);
      p += wn;
      e = 9375 / (3 * (2 << r));
      chk("bit period", p >= e && p <= e + 1, 1);
    end
    // Fast source frames: master long sync, then slave long and short.
    for (int i = 0; i < 8; i++)
    begin
      gen <= i[2];
      shs <= i[2] & i[0];
      bus(1, 8'h08, {19'h0, i[1], 12'h0});
      bus(1, 8'h04, {i[1] ? 8'h20 : 8'h04, 8'h01, 3'h0, 13'h0003});
      cv = 32'h0880_0800;
      cv[1] = i[2];
      cv[2] = i[2] & i[0];
      cv[5] = i[0];
      cv[6] = i[1];
      cv[7] = i[2];
      cv[10] = (i == 3);
      cv[12] = i[0];
      bus(1, 8'h00, cv);
      s = rnd();
      pw = rnd();
      tx_sample <= s;
      repeat (5) wt(0, 3000);
      wt(1, 3000);
      chk("tx bits", cap, (i == 3) ? 16'h0 : i[0] ? rev(s) : s);
      chk("rx sample", rx_sample, i[0] ? rev(pw) : pw);
      repeat (60) @(posedge clk_sys);
      chk("out enable", pcm_dout_oe, !i[1]);
    end
    gen <= 1'b0;
    bus(1, 8'h00, 32'h0080_0100);
    repeat (2000) @(posedge clk_sys);
    stop_test();
  end
endmodule // pcg_core_test
`default_nettype wire
